/* File: pkg/bbc_pkg.sv */
// Constants, types and helpers shared by the backlight command handler
package bbc_pkg;
  // Frame attention codes and special values
  localparam logic [7:0] ATTN_CMD = 8'h07;
  localparam logic [7:0] ATTN_ACK = 8'h06;
  localparam logic [7:0] ATTN_NAK = 8'h15;
  localparam logic [7:0] ADDR_BCAST = 8'hff;
  localparam logic [7:0] CHK_TARGET = 8'hff;
  localparam logic [7:0] LEN_READ = 8'h00;
  localparam logic [7:0] LEN_WRITE = 8'h01;
  // Command code bytes
  localparam logic [7:0] CMD_B0 = 8'h42;
  localparam logic [7:0] CMD_B1 = 8'h52;
  localparam logic [7:0] CMD_MIN = 8'h49;
  localparam logic [7:0] CMD_MAX = 8'h4d;
  localparam logic [7:0] CMD_GLB = 8'h54;
  localparam logic [7:0] CMD_LED = 8'h4c;
  localparam logic [7:0] CMD_USR = 8'h55;
  // Level reset values and panel step
  localparam logic [7:0] LVL_RESET = 8'hff;
  localparam logic [7:0] GLB_RESET = 8'h00;
  localparam logic [7:0] BTN_STEP = 8'h01;
  localparam logic [7:0] FOLLOW_MANUAL = 8'h00;
  // Non-volatile slot indices
  localparam int NV_SLOTS = 4;
  localparam logic [1:0] NV_MIN = 2'd0;
  localparam logic [1:0] NV_MAX = 2'd1;
  localparam logic [1:0] NV_LED = 2'd2;
  localparam logic [1:0] NV_USR = 2'd3;
  // Reply frame sizes
  localparam int REPLY_BYTES = 9;
  localparam logic [3:0] REPLY_LAST_ACK = 4'd8;
  localparam logic [3:0] REPLY_LAST_NAK = 4'd6;
  // APB register offsets, field positions and reset values
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LEVELS = 8'h08;
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_POT_BIT = 8;
  localparam int CTRL_FOLLOW_LSB = 16;
  localparam logic [7:0] CTRL_ADDR_RST = 8'h00;
  localparam logic CTRL_POT_RST = 1'b0;
  localparam logic [7:0] CTRL_FOLLOW_RST = 8'hff;

  typedef enum logic [3:0] {
    ST_RESTORE, ST_ATTN, ST_ADDR, ST_CMD0, ST_CMD1, ST_CMD2,
    ST_LEN, ST_HCHK, ST_DATA, ST_DCHK, ST_EXEC, ST_TX
  } bbc_state_t;

  // Product over 255 rounded down, exact over the full byte range
  function automatic logic [7:0] bbc_scale255(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    logic [15:0] q;
    p = 16'(a) * 16'(b);
    q = 16'(p + 16'd1 + (p >> 8));
    return q[15:8];
  endfunction : bbc_scale255
endpackage : bbc_pkg

/* File: core/bbc_nvm.sv */
// Non-volatile level store with per-slot written flags
`timescale 1ns/10ps
`default_nettype none
module bbc_nvm (
  // Clock and power-on clear
  input wire logic pclk,
  input wire logic ce,
  input wire logic nv_por_n,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data
);
  import bbc_pkg::*;

  logic [7:0] mem_r [NV_SLOTS];
  logic [NV_SLOTS-1:0] stored_r;

  // Contents are never reset, only their written flags at power-on
  always_ff @(posedge pclk) begin
    if (ce && wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge nv_por_n) begin
    if (!nv_por_n) begin
      stored_r <= '0;
    end else if (ce && wr_en) begin
      stored_r[wr_idx] <= 1'b1;
    end
  end

  assign rd_data = stored_r[rd_idx] ? mem_r[rd_idx] : LVL_RESET; // see RQ9
endmodule : bbc_nvm
`default_nettype wire

/* File: core/bbc_cmd.sv */
// Backlight brightness command handler with APB control registers
//
// Overview of operation
// RQ1 - Command 42 52 49 writes minimum level
// RQ2 - Command 42 52 4D writes maximum level
// RQ3 - Command 42 52 54 writes global level
// RQ4 - Command 42 52 4C sets manual LED level
// RQ5 - Command 42 52 55 writes user level
// RQ6 - Zero length reads; reply carries value
// RQ7 - Success reply: code 06, echoed header
// RQ8 - Levels are unsigned bytes, full range
// RQ9 - Reset restores stored levels, else FF
// RQ10 - Reset loads global level from factory
// RQ11 - Host keeps global between min and max
// RQ12 - User scale maps onto min-to-global span
// RQ13 - Visible follows global times user fraction
// RQ14 - Global changes only by serial command
// RQ15 - Panel buttons also change user level
// RQ16 - Valid potentiometer sets user level
// RQ17 - Visible never below minimum level
// RQ18 - Visible never above maximum level; the code drives the minimum instead when min exceeds max
// RQ19 - Header checksum sums to FF, else NAK
// RQ20 - Data checksum sums to FF, else NAK
// RQ21 - Failed or unknown command answers 15
// RQ22 - Frames not starting 07 are ignored
// RQ23 - Act on own or broadcast address only
// RQ24 - Store written level before acknowledging
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module bbc_cmd (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic nv_por_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command byte stream in
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Reply byte stream out
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Front panel pins and factory setting
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic [7:0] pot_pos,
  input wire logic [7:0] factory_global_level,
  // Drive levels
  output logic [7:0] backlight_level,
  output logic [7:0] button_led_out
);
  import bbc_pkg::*;

  bbc_state_t state_r;
  logic [7:0] sum_r, dsum_r, cnt_r, len_r, addr_r, data_r;
  logic [7:0] cmd0_r, cmd1_r, cmd2_r;
  logic hdr_ok_r, dat_ok_r;
  logic [1:0] rst_idx_r;
  logic [7:0] rep_r [REPLY_BYTES];
  logic [3:0] tx_idx_r, tx_last_r;
  logic tx_valid_r;
  logic [7:0] tx_data_r;
  logic [7:0] min_r, max_r, glb_r, usr_r, led_lvl_r;
  logic [7:0] vis_r, led_out_r;
  logic [7:0] unit_addr_r, follow_r;
  logic pot_en_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [1:0] btn_s1_r, btn_s2_r, btn_prev_r;
  logic [7:0] pot_s1_r, pot_s2_r, pot_prev_r;
  logic [7:0] nv_rd_data;
  logic known, addressed, frame_ok, do_write, nv_wr;
  logic [1:0] nv_idx;
  logic [7:0] cur_val, hdr_sum, vis_span, vis_raw;
  logic [31:0] apb_rdata;
  logic apb_err;

  // Command decode for the frame just received
  always_comb begin
    known = (cmd0_r == CMD_B0) && (cmd1_r == CMD_B1);
    nv_idx = NV_MIN;
    cur_val = min_r;
    case (cmd2_r)
      CMD_MIN: cur_val = min_r;
      CMD_MAX: begin
        cur_val = max_r;
        nv_idx = NV_MAX;
      end
      CMD_GLB: cur_val = glb_r;
      CMD_LED: begin
        cur_val = led_lvl_r;
        nv_idx = NV_LED;
      end
      CMD_USR: begin
        cur_val = usr_r;
        nv_idx = NV_USR;
      end
      default: known = 1'b0; // see RQ21
    endcase
  end

  assign addressed = (addr_r == unit_addr_r) || (addr_r == ADDR_BCAST); // see RQ23
  assign frame_ok = hdr_ok_r && dat_ok_r && known && (len_r == LEN_READ || len_r == LEN_WRITE);
  assign do_write = ce && state_r == ST_EXEC && addressed && frame_ok && len_r == LEN_WRITE;
  assign nv_wr = do_write && cmd2_r != CMD_GLB; // see RQ24
  assign hdr_sum = ~8'(ATTN_ACK + unit_addr_r + cmd0_r + cmd1_r + cmd2_r + LEN_WRITE); // see RQ7

  bbc_nvm u_nvm (
    .pclk(pclk),
    .ce(ce),
    .nv_por_n(nv_por_n),
    .wr_en(nv_wr),
    .wr_idx(nv_idx),
    .wr_data(data_r),
    .rd_idx(rst_idx_r),
    .rd_data(nv_rd_data)
  );

  // Frame receive, execute and reply sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RESTORE;
      rst_idx_r <= NV_MIN;
      sum_r <= 8'h00;
      dsum_r <= 8'h00;
      cnt_r <= 8'h00;
      len_r <= 8'h00;
      addr_r <= 8'h00;
      data_r <= 8'h00;
      cmd0_r <= 8'h00;
      cmd1_r <= 8'h00;
      cmd2_r <= 8'h00;
      hdr_ok_r <= 1'b0;
      dat_ok_r <= 1'b0;
      tx_idx_r <= 4'd0;
      tx_last_r <= 4'd0;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      for (int i = 0; i < REPLY_BYTES; i++) begin
        rep_r[i] <= 8'h00;
      end
    end else if (ce) begin
      case (state_r)
        ST_RESTORE: begin
          rst_idx_r <= 2'(rst_idx_r + 2'd1);
          if (rst_idx_r == NV_USR) begin
            state_r <= ST_ATTN;
          end
        end
        ST_EXEC: begin
          if (!addressed) begin
            state_r <= ST_ATTN;
          end else begin
            rep_r[1] <= unit_addr_r;
            rep_r[2] <= cmd0_r;
            rep_r[3] <= cmd1_r;
            rep_r[4] <= cmd2_r;
            rep_r[5] <= frame_ok ? LEN_WRITE : LEN_READ;
            rep_r[6] <= frame_ok ? hdr_sum : 8'(hdr_sum - ATTN_NAK + ATTN_ACK + LEN_WRITE);
            rep_r[7] <= (len_r == LEN_READ) ? cur_val : data_r; // see RQ6
            rep_r[8] <= (len_r == LEN_READ) ? ~cur_val : ~data_r;
            tx_last_r <= frame_ok ? REPLY_LAST_ACK : REPLY_LAST_NAK;
            tx_data_r <= frame_ok ? ATTN_ACK : ATTN_NAK; // see RQ7, see RQ19, see RQ20, see RQ21
            tx_valid_r <= 1'b1;
            tx_idx_r <= 4'd1;
            state_r <= ST_TX;
          end
        end
        ST_TX: begin
          if (tx_ready) begin
            if (tx_idx_r > tx_last_r) begin
              tx_valid_r <= 1'b0;
              state_r <= ST_ATTN;
            end else begin
              tx_data_r <= rep_r[tx_idx_r];
              tx_idx_r <= 4'(tx_idx_r + 4'd1);
            end
          end
        end
        default: begin
          // Bytes arriving while a reply is pending are dropped
          if (rx_valid) begin
            sum_r <= 8'(sum_r + rx_data);
            case (state_r)
              ST_ATTN: begin
                sum_r <= rx_data;
                if (rx_data == ATTN_CMD) begin
                  state_r <= ST_ADDR; // see RQ22
                end
              end
              ST_ADDR: begin
                addr_r <= rx_data;
                state_r <= ST_CMD0;
              end
              ST_CMD0: begin
                cmd0_r <= rx_data;
                state_r <= ST_CMD1;
              end
              ST_CMD1: begin
                cmd1_r <= rx_data;
                state_r <= ST_CMD2;
              end
              ST_CMD2: begin
                cmd2_r <= rx_data;
                state_r <= ST_LEN;
              end
              ST_LEN: begin
                len_r <= rx_data;
                cnt_r <= rx_data;
                state_r <= ST_HCHK;
              end
              ST_HCHK: begin
                hdr_ok_r <= 8'(sum_r + rx_data) == CHK_TARGET; // see RQ19
                dat_ok_r <= 1'b1;
                dsum_r <= 8'h00;
                state_r <= (len_r == LEN_READ) ? ST_EXEC : ST_DATA;
              end
              ST_DATA: begin
                if (cnt_r == len_r) begin
                  data_r <= rx_data;
                end
                dsum_r <= 8'(dsum_r + rx_data);
                cnt_r <= 8'(cnt_r - 8'd1);
                if (cnt_r == 8'd1) begin
                  state_r <= ST_DCHK;
                end
              end
              default: begin
                dat_ok_r <= 8'(dsum_r + rx_data) == CHK_TARGET; // see RQ20
                state_r <= ST_EXEC;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Panel pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_s1_r <= 2'b00;
      btn_s2_r <= 2'b00;
      btn_prev_r <= 2'b00;
      pot_s1_r <= 8'h00;
      pot_s2_r <= 8'h00;
      pot_prev_r <= 8'h00;
    end else if (ce) begin
      btn_s1_r <= {btn_up, btn_down};
      btn_s2_r <= btn_s1_r;
      btn_prev_r <= btn_s2_r;
      pot_s1_r <= pot_pos;
      pot_s2_r <= pot_s1_r;
      pot_prev_r <= pot_s2_r;
    end
  end

  // Stored levels: serial write beats potentiometer beats buttons
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_r <= LVL_RESET;
      max_r <= LVL_RESET;
      led_lvl_r <= LVL_RESET;
      usr_r <= LVL_RESET;
      glb_r <= GLB_RESET;
    end else if (ce) begin
      if (state_r == ST_RESTORE) begin
        case (rst_idx_r)
          NV_MIN: min_r <= nv_rd_data; // see RQ9
          NV_MAX: max_r <= nv_rd_data;
          NV_LED: led_lvl_r <= nv_rd_data;
          default: usr_r <= nv_rd_data;
        endcase
        glb_r <= factory_global_level; // see RQ10
      end else if (do_write) begin
        case (cmd2_r)
          CMD_MIN: min_r <= data_r; // see RQ1, see RQ8
          CMD_MAX: max_r <= data_r; // see RQ2
          CMD_GLB: glb_r <= data_r; // see RQ3, see RQ14
          CMD_LED: led_lvl_r <= data_r; // see RQ4
          default: usr_r <= data_r; // see RQ5
        endcase
      end else if (pot_en_r && pot_s2_r != pot_prev_r) begin
        usr_r <= pot_s2_r; // see RQ16
      end else if (btn_s2_r[1] && !btn_prev_r[1] && usr_r != LVL_RESET) begin
        usr_r <= 8'(usr_r + BTN_STEP); // see RQ15
      end else if (btn_s2_r[0] && !btn_prev_r[0] && usr_r != 8'h00) begin
        usr_r <= 8'(usr_r - BTN_STEP);
      end
    end
  end

  // Global above minimum is advised but not enforced; below it the span collapses
  assign vis_span = (glb_r > min_r) ? 8'(glb_r - min_r) : 8'h00;
  assign vis_raw = 8'(min_r + bbc_scale255(vis_span, usr_r)); // see RQ12, see RQ13

  // Drive levels recomputed every cycle; minimum wins if min exceeds max
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Matches the reset minimum and maximum so the clamp holds from the first edge
      vis_r <= LVL_RESET;
      led_out_r <= 8'h00;
    end else if (ce) begin
      if (vis_raw < min_r) begin
        vis_r <= min_r; // see RQ17
      end else if (vis_raw > max_r) begin
        vis_r <= (max_r < min_r) ? min_r : max_r; // see RQ18
      end else begin
        vis_r <= vis_raw;
      end
      led_out_r <= (follow_r == FOLLOW_MANUAL) ? led_lvl_r : bbc_scale255(vis_r, led_lvl_r); // see RQ4
    end
  end

  // APB read decode
  always_comb begin
    apb_err = 1'b0;
    apb_rdata = 32'h0000_0000;
    if (paddr == OFF_CTRL) begin
      apb_rdata[CTRL_ADDR_LSB +: 8] = unit_addr_r;
      apb_rdata[CTRL_POT_BIT] = pot_en_r;
      apb_rdata[CTRL_FOLLOW_LSB +: 8] = follow_r;
    end else if (paddr == OFF_STATUS) begin
      apb_rdata = {usr_r, glb_r, led_out_r, vis_r};
    end else if (paddr == OFF_LEVELS) begin
      apb_rdata = {8'h00, led_lvl_r, max_r, min_r};
    end else begin
      apb_err = 1'b1;
    end
  end

  // APB slave: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      unit_addr_r <= CTRL_ADDR_RST;
      pot_en_r <= CTRL_POT_RST;
      follow_r <= CTRL_FOLLOW_RST;
    end else if (ce) begin
      pready_r <= psel && !penable && !pready_r;
      if (psel && !penable) begin
        prdata_r <= pwrite ? 32'h0000_0000 : apb_rdata;
        pslverr_r <= apb_err;
      end
      if (psel && penable && pready_r && pwrite && paddr == OFF_CTRL) begin
        unit_addr_r <= pwdata[CTRL_ADDR_LSB +: 8];
        pot_en_r <= pwdata[CTRL_POT_BIT];
        follow_r <= pwdata[CTRL_FOLLOW_LSB +: 8];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign backlight_level = vis_r;
  assign button_led_out = led_out_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_exec_ok;
    ce && state_r == ST_EXEC && addressed && frame_ok;
  endsequence
  sequence s_exec_bad_hdr;
    ce && state_r == ST_EXEC && addressed && !hdr_ok_r;
  endsequence

  AST_ACK_CODE: assert property (s_exec_ok |=> tx_valid_r && tx_data_r == ATTN_ACK) // see RQ7
    else $error("ack code missing after good frame");
  AST_NAK_HDR: assert property (s_exec_bad_hdr |=> tx_valid_r && tx_data_r == ATTN_NAK) // see RQ19
    else $error("bad header checksum not answered with nak");
  AST_IGNORE_OTHER: assert property (ce && state_r == ST_ATTN && rx_valid && rx_data != ATTN_CMD |=> state_r == ST_ATTN) // see RQ22
    else $error("frame started without attention code");
  AST_ADDR_FILTER: assert property (ce && state_r == ST_EXEC && !addressed |=> !tx_valid_r && state_r == ST_ATTN) // see RQ23
    else $error("foreign address answered");
  AST_STORE_FIRST: assert property (nv_wr |=> tx_valid_r && tx_data_r == ATTN_ACK) // see RQ24
    else $error("store not followed by ack");
  AST_VIS_ABOVE_MIN: assert property ($past(ce) |-> vis_r >= $past(min_r)) // see RQ17
    else $error("visible level below minimum");
  AST_VIS_BELOW_MAX: assert property ($past(ce) && $past(max_r) >= $past(min_r) |-> vis_r <= $past(max_r)) // see RQ18
    else $error("visible level above maximum");
  AST_GLB_SERIAL: assert property (glb_r != $past(glb_r) |-> $past(state_r) == ST_RESTORE || $past(do_write)) // see RQ14
    else $error("global level changed without serial write");
  AST_LED_MANUAL: assert property ($past(ce) && $past(follow_r) == FOLLOW_MANUAL |-> led_out_r == $past(led_lvl_r)) // see RQ4
    else $error("manual led level not driven");
  AST_READ_REPLY: assert property (s_exec_ok ##0 len_r == LEN_READ |=> rep_r[7] == $past(cur_val) ##0 rep_r[5] == LEN_WRITE) // see RQ6
    else $error("read reply does not carry value");
endmodule : bbc_cmd
`default_nettype wire

/* File: sim/bbc_host.sv */
// Host model that sends command frames and collects reply bytes
`timescale 1ns/10ps
`default_nettype none
module bbc_host (
  // Clock and stall request
  input wire logic pclk,
  input wire logic stall,
  // Frame bytes to the device
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Reply bytes from the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] rq[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Frames arrive built with checksums and length by the caller
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    // Idle line shows the inverse so a stale byte never looks valid
    rx_data <= ~q[q.size() - 1];
  endtask : send
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) rq.push_back(tx_data);
    tx_ready <= !stall;
  end
endmodule : bbc_host
`default_nettype wire

/* File: sim/bbc_cmd_tb.sv */
// Self-checking bench for the backlight command handler
`timescale 1ns/10ps
`default_nettype none
module bbc_cmd_tb;
  import bbc_pkg::*;
  logic pclk, presetn, nv_por_n, psel, penable, pwrite, pready, pslverr, e;
  logic rx_valid, tx_valid, tx_ready, btn_up, btn_down, slow, stall;
  logic [7:0] paddr, rx_data, tx_data, pot_pos, fgl, bl, lo;
  logic [31:0] pwdata, prdata, r;
  int fails, cmp_count, seed, v, fo, ad, nvu;
  int lv[5];
  int lo_t[5] = '{0, 'hc0, 'h50, 0, 0};
  int mk[5] = '{'h3f, 'h3f, 'h3f, 'hff, 'hff};
  logic [7:0] cmds[5] = '{CMD_MIN, CMD_MAX, CMD_GLB, CMD_LED, CMD_USR};
  bbc_cmd DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .nv_por_n(nv_por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .btn_up(btn_up),
    .btn_down(btn_down), .pot_pos(pot_pos), .factory_global_level(fgl),
    .backlight_level(bl), .button_led_out(lo));
  bbc_host host (.pclk(pclk), .stall(stall), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) stall <= slow & 1'($random(seed));
  function automatic int vis();
    int x;
    x = lv[0] + ((lv[2] > lv[0]) ? (lv[2] - lv[0]) * lv[4] / 255 : 0);
    if (x > lv[1]) x = lv[1];
    if (x < lv[0]) x = lv[0];
    return x;
  endfunction : vis
  function automatic int ledv();
    return (fo == 0) ? lv[3] : vis() * lv[3] / 255;
  endfunction : ledv
  function automatic logic [31:0] ctl(input logic p);
    return {8'h00, 8'(fo), 7'h00, p, 8'(ad)};
  endfunction : ctl
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic levels();
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 0);
    chk(r, {8'(lv[4]), 8'(lv[2]), 8'(ledv()), 8'(vis())});
    chk(bl, vis());
    chk(lo, ledv());
    apb(1'b0, OFF_LEVELS, 0);
    chk(r, {8'h00, 8'(lv[3]), 8'(lv[1]), 8'(lv[0])});
  endtask : levels
  task automatic xfer(input logic [7:0] a0, c2, ln, dt, input int bad, kind, rv);
    logic [7:0] q[$];
    logic [7:0] x[$];
    logic [7:0] s;
    int n;
    q = '{(bad == 3) ? 8'h08 : ATTN_CMD, a0, CMD_B0, CMD_B1, c2, ln};
    s = 0;
    foreach (q[i]) s += q[i];
    q.push_back(8'(8'hff - s + (bad == 1)));
    if (ln != 0) begin
      repeat (ln) q.push_back(dt);
      q.push_back(8'(8'hff - ln * dt + (bad == 2)));
    end
    if (kind > 0) begin
      x = '{(kind == 2) ? ATTN_ACK : ATTN_NAK, 8'(ad), CMD_B0, CMD_B1, c2, (kind == 2) ? LEN_WRITE : LEN_READ};
      s = 0;
      foreach (x[i]) s += x[i];
      x.push_back(8'(8'hff - s));
      if (kind == 2) x.push_back(8'(rv));
      if (kind == 2) x.push_back(8'(8'hff - rv));
    end
    host.send(q);
    n = 0;
    while (host.rq.size() < x.size() && n < 200) begin
      @(posedge pclk);
      n++;
    end
    repeat (20) @(posedge pclk);
    chk(host.rq.size(), x.size());
    foreach (x[i]) if (i < host.rq.size()) chk(host.rq[i], x[i]);
    host.rq.delete();
  endtask : xfer
  task automatic btn(input logic up);
    if (up) btn_up <= 1'b1;
    else btn_down <= 1'b1;
    repeat (6) @(posedge pclk);
    btn_up <= 1'b0;
    btn_down <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : btn
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    seed = 32'h06e908d0;
    {presetn, nv_por_n, psel, penable, pwrite, btn_up, btn_down, slow} = 8'h00;
    paddr = 8'h00;
    pwdata = 0;
    pot_pos = 8'h00;
    fgl = 8'($random(seed));
    lv = '{255, 255, fgl, 255, 255};
    nvu = 255;
    fo = 255;
    ad = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    nv_por_n <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_CTRL, 0);
    chk(r, ctl(1'b0));
    apb(1'b0, 8'h0c, 0);
    chk(e, 1'b1);
    apb(1'b1, OFF_STATUS, 32'hffffffff);
    levels();
    slow = 1'b1;
    foreach (cmds[i]) begin
      v = lo_t[i] + ($random(seed) & mk[i]);
      xfer(ADDR_BCAST, cmds[i], LEN_WRITE, 8'(v), 0, 2, v);
      lv[i] = v;
      if (i == 4) nvu = v;
      levels();
    end
    slow = 1'b0;
    foreach (cmds[i]) xfer(ADDR_BCAST, cmds[i], LEN_READ, 0, 0, 2, lv[i]);
    xfer(ADDR_BCAST, CMD_MIN, LEN_WRITE, 8'h11, 1, 1, 0);
    xfer(ADDR_BCAST, CMD_MIN, LEN_WRITE, 8'h11, 2, 1, 0);
    xfer(ADDR_BCAST, 8'h41, LEN_READ, 0, 0, 1, 0);
    xfer(ADDR_BCAST, CMD_MIN, 8'h02, 8'h11, 0, 1, 0);
    xfer(ADDR_BCAST, CMD_MIN, LEN_WRITE, 8'h11, 3, 0, 0);
    ad = 5;
    apb(1'b1, OFF_CTRL, ctl(1'b0));
    xfer(8'h06, CMD_USR, LEN_READ, 0, 0, 0, 0);
    xfer(8'h05, CMD_USR, LEN_WRITE, 8'h00, 0, 2, 0);
    lv[4] = 0;
    nvu = 0;
    levels();
    btn(1'b1);
    btn(1'b1);
    btn(1'b0);
    lv[4] = 1;
    levels();
    fo = 0;
    apb(1'b1, OFF_CTRL, ctl(1'b1));
    pot_pos <= 8'hff;
    repeat (10) @(posedge pclk);
    lv[4] = 255;
    levels();
    apb(1'b1, OFF_CTRL, ctl(1'b0));
    pot_pos <= 8'h30;
    repeat (10) @(posedge pclk);
    levels();
    v = lv[2] - 16;
    xfer(8'h05, CMD_MAX, LEN_WRITE, 8'(v), 0, 2, v);
    lv[1] = v;
    levels();
    presetn <= 1'b0;
    fgl <= 8'($random(seed));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    lv[2] = fgl;
    lv[4] = nvu;
    fo = 255;
    ad = 0;
    levels();
    summarize();
  end
endmodule : bbc_cmd_tb
`default_nettype wire
